// *** src/tgc_defs.svh ***
// widths, positions and addresses of the tag cache
// assumes one capability_width location per access, byte addresses
`ifndef TGC_DEFS_SVH
`define TGC_DEFS_SVH
`define TGC_ADDR_W   32
`define TGC_CAP_W    64
`define TGC_BE_W     8
`define TGC_BE_ALL   8'hFF
`define TGC_LINES    16
`define TGC_IDX_W    4
`define TGC_LTAG_W   19
`define TGC_POS_W    6
`define TGC_POS_LO   3
`define TGC_POS_HI   8
`define TGC_IDX_LO   9
`define TGC_IDX_HI   12
`define TGC_LTAG_LO  13
`define TGC_TAG_BASE 32'hF000_0000
`endif

// *** src/tgc_pkg.sv ***
// types shared by the tag cache files
// assumes tgc_defs.svh is on the include path
`include "tgc_defs.svh"
package tgc_pkg;
	typedef struct packed {
		logic                  valid;
		logic                  we;
		logic                  clr;
		logic [`TGC_ADDR_W-1:0] addr;
		logic [`TGC_CAP_W-1:0]  wdata;
		logic                  wtag;
	} tgc_up_req_t;
	typedef struct packed {
		logic                 valid;
		logic [`TGC_CAP_W-1:0] rdata;
		logic                 rtag;
	} tgc_up_rsp_t;
	typedef struct packed {
		logic                  valid;
		logic                  we;
		logic [`TGC_ADDR_W-1:0] addr;
		logic [`TGC_CAP_W-1:0]  wdata;
		logic [`TGC_BE_W-1:0]   be;
	} tgc_pl_req_t;
	typedef struct packed {
		logic                 valid;
		logic [`TGC_CAP_W-1:0] rdata;
	} tgc_pl_rsp_t;
	typedef tgc_pl_req_t tgc_mem_req_t;
	typedef struct packed {
		logic                 ack;
		logic [`TGC_CAP_W-1:0] rdata;
	} tgc_mem_rsp_t;
	typedef struct packed {
		logic                  valid;
		logic                  dirty;
		logic [`TGC_LTAG_W-1:0] ltag;
		logic [`TGC_CAP_W-1:0]  bits;
	} tgc_line_t;
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_LOOK = 3'h1,
		S_WB   = 3'h2,
		S_FILL = 3'h3,
		S_DATA = 3'h4
	} tgc_state_t;
endpackage

// *** src/tgc_tag_ram.sv ***
// direct-mapped store of tag lines, one tag bit per location
// assumes the owner serialises all reads and writes
`include "tgc_defs.svh"
module tgc_tag_ram import tgc_pkg::*; (
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	input  wire logic [`TGC_IDX_W-1:0] rd_idx,
	output tgc_line_t                  rd_line,
	input  wire logic                  we,
	input  wire logic [`TGC_IDX_W-1:0] wr_idx,
	input  tgc_line_t                  wr_line
);
	tgc_line_t lines [`TGC_LINES];

	assign rd_line = lines[rd_idx];

	// only valid and dirty are reset; contents are refilled before use
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			for (int i = 0; i < `TGC_LINES; i++) begin
				lines[i].valid <= 1'b0;
				lines[i].dirty <= 1'b0;
			end
		end else if (we) begin
			lines[wr_idx] <= wr_line;
		end
	end
endmodule // tgc_tag_ram

// *** src/tgc_top.sv ***
// tag cache between tag-aware initiators, a plain port and untagged dram
// assumes dram holds each request steady-state and acks once with read data
`include "tgc_defs.svh"
module tgc_top import tgc_pkg::*; (
	input  wire logic   clk_sys,
	input  wire logic   rst,
	input  tgc_up_req_t up_req,
	output tgc_up_rsp_t up_rsp,
	output logic        up_rdy,
	input  tgc_pl_req_t pl_req,
	output tgc_pl_rsp_t pl_rsp,
	output logic        pl_rdy,
	output tgc_mem_req_t mem_req,
	input  tgc_mem_rsp_t mem_rsp
);
	// ----------------------------------------
	// decode
	// ----------------------------------------
	function automatic logic [`TGC_POS_W-1:0] tag_pos(input logic [`TGC_ADDR_W-1:0] a);
		return a[`TGC_POS_HI:`TGC_POS_LO];
	endfunction

	function automatic logic [`TGC_ADDR_W-1:0] tag_word(input logic [`TGC_LTAG_W-1:0] lt,
		input logic [`TGC_IDX_W-1:0] ix);
		return `TGC_TAG_BASE + {6'h00, lt, ix, 3'h0};
	endfunction

	tgc_state_t              state;
	logic [`TGC_ADDR_W-1:0]  cur_addr;
	logic [`TGC_CAP_W-1:0]   cur_wdata;
	logic [`TGC_BE_W-1:0]    cur_be;
	logic                    cur_we;
	logic                    cur_clr;
	logic                    cur_tag;
	logic                    cur_plain;
	tgc_line_t               rd_line;
	tgc_line_t               wr_line;
	logic                    ram_we;
	logic                    hit;
	logic                    take_up;
	logic                    take_pl;
	logic [`TGC_IDX_W-1:0]   cur_idx;
	logic [`TGC_LTAG_W-1:0]  cur_ltag;
	logic [`TGC_POS_W-1:0]   pos;

	assign cur_idx  = cur_addr[`TGC_IDX_HI:`TGC_IDX_LO];
	assign cur_ltag = cur_addr[`TGC_ADDR_W-1:`TGC_LTAG_LO];
	assign pos      = tag_pos(cur_addr);
	assign hit      = rd_line.valid && (rd_line.ltag == cur_ltag);
	// tag-aware port wins a tie; plain traffic waits one access
	assign take_up  = (state == S_IDLE) && up_rdy && up_req.valid;
	assign take_pl  = (state == S_IDLE) && pl_rdy && pl_req.valid && !up_req.valid;

	tgc_tag_ram u_ram (
		.clk_sys (clk_sys),
		.rst     (rst),
		.rd_idx  (cur_idx),
		.rd_line (rd_line),
		.we      (ram_we),
		.wr_idx  (cur_idx),
		.wr_line (wr_line)
	);

	// ----------------------------------------
	// tag line updates
	// ----------------------------------------
	always_comb begin
		ram_we  = 1'b0;
		wr_line = rd_line;
		if (state == S_FILL && mem_rsp.ack) begin
			ram_we  = 1'b1;
			wr_line = '{valid: 1'b1, dirty: 1'b0, ltag: cur_ltag, bits: mem_rsp.rdata};
		end else if (state == S_LOOK && hit && cur_clr) begin
			ram_we             = 1'b1;
			wr_line.dirty      = 1'b1;
			wr_line.bits[pos]  = 1'b0;
		end else if (state == S_DATA && mem_rsp.ack && cur_we && (|cur_be)) begin
			ram_we            = 1'b1;
			wr_line.dirty     = 1'b1;
			// plain writers can only clear; only the tag-aware port sets
			wr_line.bits[pos] = cur_plain ? 1'b0 : cur_tag;
		end
	end

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state <= S_IDLE;
		end else begin
			case (state)
				S_IDLE: begin
					if (take_up || take_pl) begin
						state <= S_LOOK;
					end
				end
				S_LOOK: begin
					if (hit) begin
						state <= cur_clr ? S_IDLE : S_DATA;
					end else if (rd_line.valid && rd_line.dirty) begin
						state <= S_WB;
					end else begin
						state <= S_FILL;
					end
				end
				S_WB: begin
					if (mem_rsp.ack) begin
						state <= S_FILL;
					end
				end
				S_FILL: begin
					if (mem_rsp.ack) begin
						state <= S_LOOK;
					end
				end
				S_DATA: begin
					if (mem_rsp.ack) begin
						state <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cur_addr  <= '0;
			cur_wdata <= '0;
			cur_be    <= '0;
			cur_we    <= 1'b0;
			cur_clr   <= 1'b0;
			cur_tag   <= 1'b0;
			cur_plain <= 1'b0;
		end else if (take_up) begin
			cur_addr  <= up_req.addr;
			cur_wdata <= up_req.wdata;
			cur_be    <= `TGC_BE_ALL;
			cur_we    <= up_req.we && !up_req.clr;
			cur_clr   <= up_req.clr;
			cur_tag   <= up_req.wtag;
			cur_plain <= 1'b0;
		end else if (take_pl) begin
			cur_addr  <= pl_req.addr;
			cur_wdata <= pl_req.wdata;
			cur_be    <= pl_req.be;
			cur_we    <= pl_req.we;
			cur_clr   <= 1'b0;
			cur_tag   <= 1'b0;
			cur_plain <= 1'b1;
		end
	end

	// ----------------------------------------
	// dram requests
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mem_req <= '0;
		end else if (state == S_LOOK && !hit && rd_line.valid && rd_line.dirty) begin
			mem_req <= '{valid: 1'b1, we: 1'b1, addr: tag_word(rd_line.ltag, cur_idx),
				wdata: rd_line.bits, be: `TGC_BE_ALL};
		end else if ((state == S_LOOK && !hit && !(rd_line.valid && rd_line.dirty))
			|| (state == S_WB && mem_rsp.ack)) begin
			mem_req <= '{valid: 1'b1, we: 1'b0, addr: tag_word(cur_ltag, cur_idx),
				wdata: '0, be: `TGC_BE_ALL};
		end else if (state == S_LOOK && hit && !cur_clr) begin
			mem_req <= '{valid: 1'b1, we: cur_we, addr: cur_addr, wdata: cur_wdata, be: cur_be};
		end else if (mem_rsp.ack) begin
			mem_req <= '0;
		end
	end

	// ----------------------------------------
	// answers; one access in flight keeps tag and data paired
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			up_rdy <= 1'b0;
			pl_rdy <= 1'b0;
		end else if (take_up || take_pl) begin
			up_rdy <= 1'b0;
			pl_rdy <= 1'b0;
		end else if (state == S_IDLE || up_rsp.valid || pl_rsp.valid) begin
			up_rdy <= 1'b1;
			pl_rdy <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			up_rsp <= '0;
			pl_rsp <= '0;
		end else begin
			up_rsp.valid <= 1'b0;
			pl_rsp.valid <= 1'b0;
			if (state == S_LOOK && hit && cur_clr) begin
				up_rsp <= '{valid: 1'b1, rdata: '0, rtag: 1'b0};
			end else if (state == S_DATA && mem_rsp.ack && !cur_plain) begin
				up_rsp <= '{valid: 1'b1, rdata: cur_we ? '0 : mem_rsp.rdata,
					rtag: cur_we ? 1'b0 : rd_line.bits[pos]};
			end else if (state == S_DATA && mem_rsp.ack) begin
				pl_rsp <= '{valid: 1'b1, rdata: cur_we ? '0 : mem_rsp.rdata};
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_miss_clean;
		state == S_LOOK && !hit && !(rd_line.valid && rd_line.dirty);
	endsequence
	sequence s_miss_dirty;
		state == S_LOOK && !hit && rd_line.valid && rd_line.dirty;
	endsequence

	property p_plain_clear;
		@(posedge clk_sys) disable iff (rst)
		(ram_we && state == S_DATA && cur_plain) |-> !wr_line.bits[pos];
	endproperty
	a_plain_clear: assert property (p_plain_clear) else $error("plain write left tag set");

	property p_set_needs_data;
		@(posedge clk_sys) disable iff (rst)
		(ram_we && state != S_FILL && wr_line.bits[pos] && !rd_line.bits[pos])
			|-> (state == S_DATA && cur_we && !cur_plain && mem_rsp.ack && mem_req.we);
	endproperty
	a_set_needs_data: assert property (p_set_needs_data) else $error("tag set without data write");

	property p_clr_only;
		@(posedge clk_sys) disable iff (rst)
		(state == S_LOOK && hit && cur_clr) |=> (!mem_req.valid && up_rsp.valid && state == S_IDLE);
	endproperty
	a_clr_only: assert property (p_clr_only) else $error("tag clear touched dram");

	property p_miss_fetch;
		@(posedge clk_sys) disable iff (rst)
		s_miss_clean |=> (mem_req.valid && !mem_req.we && mem_req.addr == tag_word(cur_ltag, cur_idx));
	endproperty
	a_miss_fetch: assert property (p_miss_fetch) else $error("miss did not fetch tag line");

	property p_wb_first;
		@(posedge clk_sys) disable iff (rst)
		s_miss_dirty |=> (mem_req.we && state == S_WB) ##[1:1000] (state == S_FILL && !mem_req.we);
	endproperty
	a_wb_first: assert property (p_wb_first) else $error("dirty line evicted unwritten");

	property p_fill_hit;
		@(posedge clk_sys) disable iff (rst)
		(state == S_FILL && mem_rsp.ack) |=> (state == S_LOOK && hit);
	endproperty
	a_fill_hit: assert property (p_fill_hit) else $error("fill did not hit");

	property p_read_pair;
		@(posedge clk_sys) disable iff (rst)
		(state == S_DATA && mem_rsp.ack && !cur_we && !cur_plain)
			|=> (up_rsp.valid && up_rsp.rdata == $past(mem_rsp.rdata) && up_rsp.rtag == $past(rd_line.bits[pos]));
	endproperty
	a_read_pair: assert property (p_read_pair) else $error("read tag and data unpaired");

	property p_serial;
		@(posedge clk_sys) disable iff (rst)
		(take_up || take_pl) |=> (!up_rdy && !pl_rdy && state == S_LOOK);
	endproperty
	a_serial: assert property (p_serial) else $error("second access let in");

	property p_plain_no_tag;
		@(posedge clk_sys) disable iff (rst)
		pl_rsp.valid |-> !up_rsp.valid;
	endproperty
	a_plain_no_tag: assert property (p_plain_no_tag) else $error("plain answer on tagged port");
endmodule // tgc_top

// *** sim/tgc_dram_model.sv ***
// plain dram behind the tag cache: data and tag region in one sparse array
// assumes requests are held until ack; ack is a one-cycle pulse
`include "tgc_defs.svh"
module tgc_dram_model import tgc_pkg::*; (
	input  wire logic   clk_sys,
	input  wire logic   rst,
	input  wire logic   slow,
	input  tgc_mem_req_t mem_req,
	output tgc_mem_rsp_t mem_rsp
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [63:0] mem [logic [31:0]];
	int          wait_cnt;
	int          n_ack = 0;
	logic [31:0] k;
	logic [63:0] m;
	// ---------------------------------------------
	// answer after 0 or 3 wait cycles
	// ---------------------------------------------
	// rdata toggles outside ack so a stale sample never matches
	// the cache is the only initiator wired here: no peripheral or dma path reaches either region
	always @(posedge clk_sys) begin
		if (rst) begin
			mem_rsp <= '0;
			wait_cnt <= 0;
		end else if (mem_req.valid && !mem_rsp.ack && wait_cnt >= (slow ? 3 : 0)) begin
			k = {mem_req.addr[31:3], 3'h0};
			m = mem.exists(k) ? mem[k] : 64'h0;
			for (int b = 0; b < 8; b++) if (mem_req.we && mem_req.be[b]) m[8*b +: 8] = mem_req.wdata[8*b +: 8];
			if (mem_req.we) mem[k] = m;
			mem_rsp <= '{1'b1, mem_req.we ? ~m : m};
			n_ack++;
			wait_cnt <= 0;
		end else begin
			mem_rsp <= '{1'b0, ~mem_rsp.rdata};
			wait_cnt <= (mem_req.valid && !mem_rsp.ack) ? wait_cnt + 1 : 0;
		end
	end
endmodule // tgc_dram_model

// *** sim/tgc_top_tb_top.sv ***
// self-checking bench for the tag cache: table of accesses, then hand tests
// assumes a 100 MHz clock, the dram model and the design files on the path
`include "tgc_defs.svh"
module tgc_top_tb_top import tgc_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {
		logic        port;
		logic        we;
		logic        clr;
		logic [31:0] addr;
		logic [63:0] wdata;
		logic        wtag;
		logic [7:0]  be;
		logic [63:0] edata;
		logic        etag;
	} tgc_row_t;
	logic         clk_sys = 1'b0;
	logic         rst = 1'b1;
	logic         slow = 1'b0;
	tgc_up_req_t  up_req = '0;
	tgc_up_rsp_t  up_rsp;
	logic         up_rdy;
	tgc_pl_req_t  pl_req = '0;
	tgc_pl_rsp_t  pl_rsp;
	logic         pl_rdy;
	tgc_mem_req_t mem_req;
	tgc_mem_rsp_t mem_rsp;
	tgc_row_t     rows[$];
	int           n_fail = 0;
	int           check_count = 0;
	int           cyc = 0;
	int           na;
	logic [63:0]  d;
	logic         t;
	logic         early;
	localparam logic [31:0] A = 32'h0000_0100;
	localparam logic [31:0] B = 32'h0000_2100;
	always #5 clk_sys = ~clk_sys;
	tgc_top tgc_top_inst (.clk_sys(clk_sys), .rst(rst), .up_req(up_req), .up_rsp(up_rsp), .up_rdy(up_rdy),
		.pl_req(pl_req), .pl_rsp(pl_rsp), .pl_rdy(pl_rdy), .mem_req(mem_req), .mem_rsp(mem_rsp));
	tgc_dram_model tgc_dram_model_inst (.clk_sys(clk_sys), .rst(rst), .slow(slow), .mem_req(mem_req),
		.mem_rsp(mem_rsp));
	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// a hang anywhere ends the run as a mismatch
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic add(input logic p, we, c, input logic [31:0] a, input logic [63:0] w, input logic wt,
		input logic [7:0] be, input logic [63:0] ed, input logic et);
		rows.push_back('{p, we, c, a, w, wt, be, ed, et});
	endtask
	// raise valid once rdy is seen, drop it after the taking edge, wait for the answer
	task automatic do_op(input tgc_row_t r, output logic [63:0] rd, output logic rt);
		int k;
		k = 0;
		@(negedge clk_sys);
		while (((r.port ? pl_rdy : up_rdy) !== 1'b1) && k < 200) begin
			@(negedge clk_sys);
			k++;
		end
		if (r.port) pl_req = '{1'b1, r.we, r.addr, r.wdata, r.be};
		else up_req = '{1'b1, r.we, r.clr, r.addr, r.wdata, r.wtag};
		@(negedge clk_sys);
		pl_req.valid = 1'b0;
		up_req.valid = 1'b0;
		k = 0;
		while (k < 200) begin
			@(posedge clk_sys);
			#1;
			if (r.port ? (pl_rsp.valid === 1'b1) : (up_rsp.valid === 1'b1)) break;
			k++;
		end
		chk("response within bound", 64'h1, {63'h0, k < 200});
		rd = r.port ? pl_rsp.rdata : up_rsp.rdata;
		rt = r.port ? 1'b0 : up_rsp.rtag;
	endtask
	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		add(0, 1, 0, A, 64'h1111_2222_3333_4444, 1, 8'hFF, 64'h0, 0);
		add(0, 0, 0, A, 64'h0, 0, 8'hFF, 64'h1111_2222_3333_4444, 1);
		add(1, 0, 0, A, 64'h0, 0, 8'h00, 64'h1111_2222_3333_4444, 0);
		add(1, 1, 0, A, 64'hAAAA_AAAA_AAAA_AA55, 0, 8'h01, 64'h0, 0);
		add(0, 0, 0, A, 64'h0, 0, 8'hFF, 64'h1111_2222_3333_4455, 0);
		add(0, 1, 0, A, 64'h1111_2222_3333_4444, 1, 8'hFF, 64'h0, 0);
		add(1, 1, 0, A, 64'hFFFF_FFFF_FFFF_FFFF, 0, 8'h00, 64'h0, 0);
		add(0, 0, 0, A, 64'h0, 0, 8'hFF, 64'h1111_2222_3333_4444, 1);
		add(0, 0, 1, A, 64'h0, 1, 8'hFF, 64'h0, 0);
		add(0, 0, 0, A, 64'h0, 0, 8'hFF, 64'h1111_2222_3333_4444, 0);
		add(0, 1, 0, A, 64'h0123_4567_89AB_CDEF, 1, 8'hFF, 64'h0, 0);
		add(0, 1, 0, B, 64'hFEDC_BA98_7654_3210, 1, 8'hFF, 64'h0, 0);
		add(0, 0, 0, A, 64'h0, 0, 8'hFF, 64'h0123_4567_89AB_CDEF, 1);
		add(0, 0, 0, B, 64'h0, 0, 8'hFF, 64'hFEDC_BA98_7654_3210, 1);
		add(0, 1, 0, B, 64'hFEDC_BA98_7654_3210, 0, 8'hFF, 64'h0, 0);
		add(0, 0, 0, B, 64'h0, 0, 8'hFF, 64'hFEDC_BA98_7654_3210, 0);
		repeat (5) @(negedge clk_sys);
		chk("rdy low in reset", 64'h0, {62'h0, up_rdy, pl_rdy});
		chk("dram idle in reset", 64'h0, {63'h0, mem_req.valid});
		repeat (5) @(negedge clk_sys);
		rst = 1'b0;
		$display("test reset done");
		foreach (rows[i]) begin
			slow = i[0];
			do_op(rows[i], d, t);
			chk($sformatf("row %0d data", i), rows[i].edata, d);
			chk($sformatf("row %0d tag", i), {63'h0, rows[i].etag}, {63'h0, t});
		end
		$display("test table done");
		// dirty line of A went back to the tag region when B displaced it
		chk("tag word of A", 64'h0000_0001_0000_0000, tgc_dram_model_inst.mem[`TGC_TAG_BASE]);
		slow = 1'b0;
		na = tgc_dram_model_inst.n_ack;
		do_op('{0, 0, 0, 32'h0000_0A00, 64'h0, 0, 8'hFF, 64'h0, 0}, d, t);
		chk("miss dram accesses", 64'd2, 64'(tgc_dram_model_inst.n_ack - na));
		na = tgc_dram_model_inst.n_ack;
		do_op('{0, 0, 0, 32'h0000_0A00, 64'h0, 0, 8'hFF, 64'h0, 0}, d, t);
		chk("hit dram accesses", 64'd1, 64'(tgc_dram_model_inst.n_ack - na));
		$display("test miss split done");
		// both ports at once: tag-aware side first, plain side after
		// raise only once rdy is back, or the request is dropped before any edge takes it
		@(negedge clk_sys);
		while (up_rdy !== 1'b1) @(negedge clk_sys);
		up_req = '{1'b1, 1'b0, 1'b0, A, 64'h0, 1'b0};
		pl_req = '{1'b1, 1'b0, B, 64'h0, 8'h00};
		@(negedge clk_sys);
		up_req.valid = 1'b0;
		early = 1'b0;
		na = 0;
		while (up_rsp.valid !== 1'b1 && na < 200) begin
			@(posedge clk_sys);
			#1;
			early = early | (pl_rsp.valid === 1'b1);
			na++;
		end
		chk("up answer data", 64'h0123_4567_89AB_CDEF, up_rsp.rdata);
		chk("plain not answered first", 64'h0, {63'h0, early});
		// plain request stays up until the edge after rdy returns has taken it
		while (pl_rdy !== 1'b1) @(negedge clk_sys);
		@(negedge clk_sys);
		pl_req.valid = 1'b0;
		na = 0;
		while (pl_rsp.valid !== 1'b1 && na < 200) begin
			@(posedge clk_sys);
			#1;
			na++;
		end
		chk("plain answer data", 64'hFEDC_BA98_7654_3210, pl_rsp.rdata);
		$display("test priority done");
		tally_and_finish();
	end
endmodule // tgc_top_tb_top
